// ### cephs_consts.svh
// constants for the control endpoint packet-ready handshake
`ifndef CEPHS_CONSTS_SVH
`define CEPHS_CONSTS_SVH
`define CEPHS_BUF_DEPTH      32
`define CEPHS_CNT_W          6
`define CEPHS_PTR_W          5
`define CEPHS_STAT_RX_RDY    0
`define CEPHS_STAT_TX_RDY    1
`define CEPHS_EN_RX_RDY      6
`define CEPHS_EN_TX_RDY      7
`define CEPHS_EN_BULK_RX     0
`define CEPHS_STAT_RST       8'h02
`define CEPHS_EN_RST         8'h00
`define CEPHS_CNT_RST        6'h00
`endif

// ### cephs_pkg.sv
// types for the control endpoint packet-ready handshake
package cephs_pkg;
  typedef enum logic [3:0] {
    CEPHS_IDLE  = 4'b0001,
    CEPHS_RX    = 4'b0010,
    CEPHS_TXRDY = 4'b0100,
    CEPHS_TXACK = 4'b1000
  } cephs_state_t;
  typedef logic [7:0] cephs_byte_t;
endpackage

// ### cephs_skid.sv
// two-entry buffer with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module cephs_skid
  import cephs_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire cephs_byte_t in_data,
  input  wire logic        in_valid,
  output logic             in_ready,
  output cephs_byte_t      out_data,
  output logic             out_valid,
  input  wire logic        out_ready
);
  cephs_byte_t mem [2];
  logic        wr_ptr;
  logic        rd_ptr;
  logic [1:0]  count;
  wire         do_wr = clk_en && in_valid && in_ready;
  wire         do_rd = clk_en && out_valid && out_ready;

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
      mem[0] <= 8'h00;
      mem[1] <= 8'h00;
    end else begin
      if (do_wr) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= ~wr_ptr;
      end
      if (do_rd)
        rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, do_wr} - {1'b0, do_rd};
    end
  end
endmodule
`default_nettype wire

// ### cephs_buf.sv
// byte buffer with fill count, one packet deep
`timescale 1ns/10ps
`default_nettype none
`include "cephs_consts.svh"
module cephs_buf
  import cephs_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    resetn,
  input  wire logic                    clk_en,
  input  wire logic                    clear,
  input  wire logic                    wr_en,
  input  wire cephs_byte_t             wr_data,
  input  wire logic                    rd_en,
  output cephs_byte_t                  rd_data,
  output logic [`CEPHS_CNT_W-1:0]      count,
  output logic                         full,
  output logic                         empty
);
  cephs_byte_t                 mem [`CEPHS_BUF_DEPTH];
  logic [`CEPHS_PTR_W-1:0]     wr_ptr;
  logic [`CEPHS_PTR_W-1:0]     rd_ptr;
  wire do_wr = wr_en && !full;
  wire do_rd = rd_en && !empty;

  assign full    = (count == 6'(`CEPHS_BUF_DEPTH));
  assign empty   = (count == 6'h00);
  assign rd_data = mem[rd_ptr];

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wr_ptr <= 5'h00;
      rd_ptr <= 5'h00;
      count  <= `CEPHS_CNT_RST;
    end else if (clk_en) begin
      if (clear) begin
        wr_ptr <= 5'h00;
        rd_ptr <= 5'h00;
        count  <= `CEPHS_CNT_RST;
      end else begin
        if (do_wr) begin
          mem[wr_ptr] <= wr_data;
          wr_ptr      <= wr_ptr + 5'h01;
        end
        if (do_rd)
          rd_ptr <= rd_ptr + 5'h01;
        count <= count + {5'h00, do_wr} - {5'h00, do_rd};
      end
    end
  end
endmodule
`default_nettype wire

// ### cephs_top.sv
// control endpoint packet-ready handshake, data stage
// Summary of operation
// - in a control write data stage, receive-ready sets only after end-of-packet with clean stored data.
// - end-of-packet closes a received packet whether it is full size or short.
// - receive-ready raises the interrupt only when its enable bit is set.
// - in a control read data stage with the buffer writable, transmit-ready is cleared.
// - clearing transmit-ready raises the interrupt when its enable bit is set.
// - for later packets, the transmit interrupt waits for the host's ACK of the last packet.
// - setting transmit-ready arms sending on the next IN token and drops the interrupt one clock after the ready bit sets.
// - fewer bytes than the maximum are sent as a short packet.
// - bulk endpoints raise receive-ready interrupts when their data can be read.
// - all causes share one active-low interrupt output.
`timescale 1ns/10ps
`default_nettype none
`include "cephs_consts.svh"
module cephs_top
  import cephs_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 resetn,
  input  wire logic                 clk_en,
  // usb side, same clock
  input  wire logic                 setup_to_data,
  input  wire logic                 xfer_is_read,
  input  wire logic                 status_stage,
  input  wire cephs_byte_t          rx_byte,
  input  wire logic                 rx_byte_valid,
  input  wire logic                 rx_eop,
  input  wire logic                 rx_error,
  input  wire logic                 in_token,
  input  wire logic                 host_ack,
  output cephs_byte_t               tx_byte,
  output logic                      tx_byte_valid,
  input  wire logic                 tx_byte_ready,
  output logic                      tx_eop,
  // bulk endpoints
  input  wire logic                 bulk_rx_avail,
  // local microcontroller side
  input  wire logic                 status_wr,
  input  wire cephs_byte_t          status_wdata,
  input  wire logic                 enable_wr,
  input  wire cephs_byte_t          enable_wdata,
  input  wire logic                 rx_rd,
  output cephs_byte_t               rx_rdata,
  input  wire logic                 tx_wr,
  input  wire cephs_byte_t          tx_wdata,
  output cephs_byte_t               control_ep_status_reg,
  output cephs_byte_t               irq_enable_reg_one,
  output logic [`CEPHS_CNT_W-1:0]   control_ep_rx_byte_count,
  output logic                      irq_request_n
);
  // ****************************************************************
  // state and status
  // ****************************************************************
  cephs_state_t state;
  cephs_state_t next_state;
  logic         rx_rdy;
  logic         tx_rdy;
  logic         rx_bad;
  logic         first_pkt;
  logic         bulk_pend;
  logic         bulk_q;
  cephs_byte_t  en_reg;
  logic         rx_full;

  wire rx_clr   = status_wr && status_wdata[`CEPHS_STAT_RX_RDY];
  wire tx_set   = status_wr && status_wdata[`CEPHS_STAT_TX_RDY];
  wire bulk_clr = status_wr && status_wdata[`CEPHS_EN_BULK_RX];
  wire rx_done  = (state == CEPHS_RX) && rx_eop && !rx_bad && !rx_error;
  wire tx_free  = (state == CEPHS_IDLE) && setup_to_data && xfer_is_read;
  wire acked    = (state == CEPHS_TXACK) && host_ack;
  wire sending  = (state == CEPHS_TXACK) && !host_ack;
  wire bulk_rise = bulk_rx_avail && !bulk_q;

  // ****************************************************************
  // packet sequencer
  // ****************************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      CEPHS_IDLE: begin
        if (setup_to_data && !xfer_is_read)
          next_state = CEPHS_RX;
        else if (tx_free)
          next_state = CEPHS_TXRDY;
      end
      CEPHS_RX: begin
        if (status_stage)
          next_state = CEPHS_IDLE;
      end
      CEPHS_TXRDY: begin
        if (status_stage)
          next_state = CEPHS_IDLE;
        else if (tx_rdy && in_token)
          next_state = CEPHS_TXACK;
      end
      CEPHS_TXACK: begin
        if (status_stage)
          next_state = CEPHS_IDLE;
        else if (host_ack)
          next_state = CEPHS_TXRDY;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state     <= CEPHS_IDLE;
      rx_rdy    <= 1'b0;
      tx_rdy    <= 1'b1;
      rx_bad    <= 1'b0;
      first_pkt <= 1'b1;
      bulk_pend <= 1'b0;
      bulk_q    <= 1'b0;
      en_reg    <= `CEPHS_EN_RST;
    end else if (clk_en) begin
      state  <= next_state;
      bulk_q <= bulk_rx_avail;
      if (enable_wr)
        en_reg <= enable_wdata;
      // set wins over firmware clear
      if (rx_done)
        rx_rdy <= 1'b1;
      else if (rx_clr)
        rx_rdy <= 1'b0;
      if (rx_eop || state != CEPHS_RX)
        rx_bad <= 1'b0;
      else if (rx_error || (rx_byte_valid && rx_full))
        rx_bad <= 1'b1;
      // ready bit returns low at the start of a read data stage or once the host has acked
      if (tx_free || acked)
        tx_rdy <= 1'b0;
      else if (tx_set && state == CEPHS_TXRDY)
        tx_rdy <= 1'b1;
      if (tx_free)
        first_pkt <= 1'b1;
      else if (acked)
        first_pkt <= 1'b0;
      if (bulk_rise)
        bulk_pend <= 1'b1;
      else if (bulk_clr)
        bulk_pend <= 1'b0;
    end
  end

  // ****************************************************************
  // receive buffer
  // ****************************************************************
  wire  rx_wr = clk_en && (state == CEPHS_RX) && rx_byte_valid && !rx_rdy;
  // a new packet restarts the buffer only after firmware released the last one;
  // a bad packet is dropped at its end, clearing its bytes from the count
  wire  rx_drop    = (state == CEPHS_RX) && rx_eop && !rx_rdy && (rx_bad || rx_error);
  wire  rx_restart = (rx_clr && !rx_done) || rx_drop;

  cephs_buf u_rx_buf (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .clear    (rx_restart),
    .wr_en    (rx_wr),
    .wr_data  (rx_byte),
    .rd_en    (rx_rd),
    .rd_data  (rx_rdata),
    .count    (control_ep_rx_byte_count),
    .full     (rx_full),
    .empty    ()
  );

  // ****************************************************************
  // transmit buffer and output skid
  // ****************************************************************
  cephs_byte_t tx_q_data;
  logic        tx_empty;
  logic        skid_ready;
  logic        tx_push;
  logic        tx_last;
  wire         tx_pop  = sending && !tx_empty && skid_ready;

  cephs_buf u_tx_buf (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .clear    (tx_free),
    .wr_en    (tx_wr && !tx_rdy),
    .wr_data  (tx_wdata),
    .rd_en    (tx_pop),
    .rd_data  (tx_q_data),
    .count    (),
    .full     (),
    .empty    (tx_empty)
  );

  cephs_skid u_skid (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .clk_en    (clk_en),
    .in_data   (tx_q_data),
    .in_valid  (tx_pop),
    .in_ready  (skid_ready),
    .out_data  (tx_byte),
    .out_valid (tx_byte_valid),
    .out_ready (tx_byte_ready)
  );

  // short or null packet ends when the buffer drains
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      tx_push <= 1'b0;
      tx_last <= 1'b0;
    end else if (clk_en) begin
      tx_push <= sending && tx_empty && !tx_last && !tx_push && !tx_byte_valid;
      tx_last <= sending && (tx_last || tx_push);
    end
  end
  assign tx_eop = tx_push;

  // ****************************************************************
  // status and interrupt
  // ****************************************************************
  wire irq_any = (rx_rdy && en_reg[`CEPHS_EN_RX_RDY])
              || (!tx_rdy && (state == CEPHS_TXRDY)
                  && en_reg[`CEPHS_EN_TX_RDY])
              || (bulk_pend && en_reg[`CEPHS_EN_BULK_RX]);
  logic irq_q;
  always_ff @(posedge core_clk) begin
    if (!resetn)
      irq_q <= 1'b0;
    else if (clk_en)
      irq_q <= irq_any;
  end
  assign irq_request_n = !irq_q;

  always_comb begin
    control_ep_status_reg = 8'h00;
    control_ep_status_reg[`CEPHS_STAT_RX_RDY] = rx_rdy;
    control_ep_status_reg[`CEPHS_STAT_TX_RDY] = tx_rdy;
  end
  assign irq_enable_reg_one = en_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_eop_clean;
    (state == CEPHS_RX) && rx_eop && !rx_bad && !rx_error;
  endsequence

  sequence s_tx_freed;
    clk_en && tx_free && !enable_wr && en_reg[`CEPHS_EN_TX_RDY];
  endsequence

  sequence s_tx_acked;
    clk_en && acked && !status_stage && !enable_wr && en_reg[`CEPHS_EN_TX_RDY];
  endsequence

  a_rx_ready_set: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en and s_eop_clean) |=> rx_rdy)
    else $error("receive ready not set after clean end of packet");
  a_rx_no_eop: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(rx_rdy) |-> $past(rx_eop))
    else $error("receive ready set without end of packet");
  a_rx_irq: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && rx_rdy && en_reg[`CEPHS_EN_RX_RDY] |=> !irq_request_n)
    else $error("enabled receive ready did not raise interrupt");
  a_tx_clear: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && tx_free |=> !tx_rdy)
    else $error("transmit ready not cleared at data stage");
  a_tx_hold_ack: assert property (@(posedge core_clk) disable iff (!resetn)
    (state == CEPHS_TXACK) && !host_ack && !status_stage |=> tx_rdy)
    else $error("transmit ready dropped before host ack");
  a_tx_set_irq: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && tx_set && state == CEPHS_TXRDY && !rx_rdy && !bulk_pend && !bulk_rise ##1 clk_en
      |=> irq_request_n)
    else $error("interrupt not released after transmit ready set");
  a_irq_mask: assert property (@(posedge core_clk) disable iff (!resetn)
    !irq_request_n && $past(clk_en) |-> $past(irq_any))
    else $error("interrupt asserted with nothing enabled pending");
  a_bulk_irq: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && bulk_rise && en_reg[`CEPHS_EN_BULK_RX] ##1 clk_en |=> !irq_request_n)
    else $error("bulk receive did not raise interrupt");
  a_tx_irq_raise: assert property (@(posedge core_clk) disable iff (!resetn)
    s_tx_freed ##1 clk_en |=> !irq_request_n)
    else $error("enabled transmit ready did not raise interrupt");
  a_tx_ack_irq: assert property (@(posedge core_clk) disable iff (!resetn)
    s_tx_acked ##1 clk_en |=> !irq_request_n)
    else $error("interrupt not raised after host ack");
  a_tx_later_ack: assert property (@(posedge core_clk) disable iff (!resetn)
    $fell(tx_rdy) && !first_pkt |-> $past(acked))
    else $error("later transmit ready cleared without host ack");
  a_tx_eop_once: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && tx_eop |=> !tx_eop)
    else $error("packet end lasted more than one cycle");
  a_irq_release: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && !irq_any |=> irq_request_n)
    else $error("interrupt held with nothing enabled pending");
  a_rx_drop_bad: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && rx_drop |=> control_ep_rx_byte_count == `CEPHS_CNT_RST)
    else $error("bad packet bytes left in receive buffer");
endmodule
`default_nettype wire

// ### cephs_host_model.sv
// host-side model: issues IN, sinks the byte stream, answers ACK
`timescale 1ns/10ps
`default_nettype none
module cephs_host_model
  import cephs_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        start,
  output logic             in_token,
  input  wire cephs_byte_t tx_byte,
  input  wire logic        tx_byte_valid,
  output logic             tx_byte_ready,
  input  wire logic        tx_eop,
  output logic             host_ack,
  output cephs_byte_t      got [0:3],
  output int               got_n,
  output logic             got_eop
);
  logic [2:0] ack_dly;
  // ready toggles so every multi-byte stream sees stalls
  always @(posedge core_clk) begin
    if (!resetn) begin
      in_token <= 1'b0;
      tx_byte_ready <= 1'b0;
      host_ack <= 1'b0;
      ack_dly <= 3'h0;
      got_n <= 0;
      got_eop <= 1'b0;
    end else begin
      in_token <= start;
      tx_byte_ready <= ~tx_byte_ready;
      ack_dly <= {ack_dly[1:0], tx_eop};
      host_ack <= ack_dly[2];
      if (start) begin
        got_n <= 0;
        got_eop <= 1'b0;
      end else begin
        if (tx_byte_valid && tx_byte_ready) begin
          got[got_n[1:0]] <= tx_byte;
          got_n <= got_n + 1;
        end
        if (tx_eop) got_eop <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### cephs_top_tb.sv
// self-checking testbench for the control endpoint handshake
`timescale 1ns/10ps
`default_nettype none
module cephs_top_tb
  import cephs_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        setup_to_data = 1'b0, xfer_is_read = 1'b0, status_stage = 1'b0;
  cephs_byte_t rx_byte = 8'h00, status_wdata = 8'h00, enable_wdata = 8'h00, tx_wdata = 8'h00;
  logic        rx_byte_valid = 1'b0, rx_eop = 1'b0, rx_error = 1'b0;
  logic        status_wr = 1'b0, enable_wr = 1'b0, rx_rd = 1'b0, tx_wr = 1'b0;
  logic        bulk_rx_avail = 1'b0, host_start = 1'b0;
  logic        in_token, host_ack, tx_byte_valid, tx_byte_ready, tx_eop, irq_request_n;
  cephs_byte_t tx_byte, rx_rdata, control_ep_status_reg, irq_enable_reg_one;
  logic [5:0]  control_ep_rx_byte_count;
  cephs_byte_t got [0:3];
  int          got_n;
  logic        got_eop;
  int          fail_count = 0;
  int          checks = 0;

  always #50 core_clk = ~core_clk;

  cephs_top u_cephs_top (.core_clk(core_clk), .resetn(resetn), .clk_en(1'b1),
    .setup_to_data(setup_to_data), .xfer_is_read(xfer_is_read), .status_stage(status_stage),
    .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid), .rx_eop(rx_eop), .rx_error(rx_error),
    .in_token(in_token), .host_ack(host_ack), .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid),
    .tx_byte_ready(tx_byte_ready), .tx_eop(tx_eop), .bulk_rx_avail(bulk_rx_avail),
    .status_wr(status_wr), .status_wdata(status_wdata), .enable_wr(enable_wr),
    .enable_wdata(enable_wdata), .rx_rd(rx_rd), .rx_rdata(rx_rdata), .tx_wr(tx_wr),
    .tx_wdata(tx_wdata), .control_ep_status_reg(control_ep_status_reg),
    .irq_enable_reg_one(irq_enable_reg_one),
    .control_ep_rx_byte_count(control_ep_rx_byte_count), .irq_request_n(irq_request_n));

  cephs_host_model u_cephs_host_model (.core_clk(core_clk), .resetn(resetn), .start(host_start),
    .in_token(in_token), .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid),
    .tx_byte_ready(tx_byte_ready), .tx_eop(tx_eop), .host_ack(host_ack), .got(got),
    .got_n(got_n), .got_eop(got_eop));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic tick(input int n = 1);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (fail_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic stat_wr(input cephs_byte_t d);
    status_wdata = d;
    status_wr = 1'b1;
    tick();
    status_wr = 1'b0;
    tick(2);
  endtask

  task automatic en_wr(input cephs_byte_t d);
    enable_wdata = d;
    enable_wr = 1'b1;
    tick();
    enable_wr = 1'b0;
  endtask

  task automatic enter_data(input logic rd);
    xfer_is_read = rd;
    setup_to_data = 1'b1;
    tick();
    setup_to_data = 1'b0;
    tick(2);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    check("status", control_ep_status_reg, 8'h02);
    check("enable", irq_enable_reg_one, 8'h00);
    check("count", control_ep_rx_byte_count, 6'h00);
    check("irq", irq_request_n, 1'b1);
  endtask

  // back-to-back bytes, then end of packet, optional error inside
  task automatic t_rx_pkt(input int n, input logic err);
    rx_byte_valid = 1'b1;
    for (int i = 0; i < n; i++) begin
      rx_byte = 8'h10 + i[7:0];
      rx_error = err && (i == 0);
      tick();
    end
    rx_byte_valid = 1'b0;
    rx_error = 1'b0;
    rx_eop = 1'b1;
    tick();
    rx_eop = 1'b0;
    tick(2);
    check("rx ready", control_ep_status_reg[0], !err);
    check("irq rx", irq_request_n, err);
    if (!err) begin
      check("rx count", control_ep_rx_byte_count, n);
      rx_rd = 1'b1;
      for (int i = 0; i < n; i++) begin
        check("rx data", rx_rdata, 8'h10 + i);
        tick();
      end
      rx_rd = 1'b0;
      stat_wr(8'h01);
      check("rx clear", control_ep_status_reg[0], 1'b0);
      check("irq rx off", irq_request_n, 1'b1);
    end else begin
      check("rx drop", control_ep_rx_byte_count, 6'h00);
    end
  endtask

  task automatic t_write();
    en_wr(8'h40);
    enter_data(1'b0);
    t_rx_pkt(3, 1'b0);
    t_rx_pkt(32, 1'b0);
    t_rx_pkt(2, 1'b1);
    status_stage = 1'b1;
    tick();
    status_stage = 1'b0;
  endtask

  // two short packets; the second one only after the host's ACK
  task automatic t_read();
    en_wr(8'h80);
    enter_data(1'b1);
    check("tx ready", control_ep_status_reg[1], 1'b0);
    check("irq tx", irq_request_n, 1'b0);
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 3 - 2 * p; i++) begin
        tx_wdata = 8'hc0 + i[7:0] + p[7:0];
        tx_wr = 1'b1;
        tick();
      end
      tx_wr = 1'b0;
      stat_wr(8'h02);
      check("tx armed", control_ep_status_reg[1], 1'b1);
      check("irq armed", irq_request_n, 1'b1);
      host_start = 1'b1;
      tick();
      host_start = 1'b0;
      for (int w = 0; w < 100 && !got_eop; w++) tick();
      check("tx count", got_n, 3 - 2 * p);
      for (int i = 0; i < 3 - 2 * p; i++) check("tx data", got[i], 8'hc0 + i + p);
      check("irq before ack", irq_request_n, 1'b1);
      for (int w = 0; w < 20 && control_ep_status_reg[1] !== 1'b0; w++) tick();
      tick(2);
      check("tx free", control_ep_status_reg[1], 1'b0);
      check("irq after ack", irq_request_n, 1'b0);
    end
  endtask

  task automatic t_bulk();
    en_wr(8'h00);
    tick(2);
    check("irq masked", irq_request_n, 1'b1);
    en_wr(8'h01);
    bulk_rx_avail = 1'b1;
    tick(3);
    check("enable", irq_enable_reg_one, 8'h01);
    check("irq bulk", irq_request_n, 1'b0);
    stat_wr(8'h01);
    check("irq bulk off", irq_request_n, 1'b1);
    en_wr(8'h81);
    tick();
    check("irq tx pending", irq_request_n, 1'b0);
    stat_wr(8'h02);
    check("irq all clear", irq_request_n, 1'b1);
  endtask

  initial begin
    tick(2);
    resetn = 1'b1;
    t_reset();
    t_write();
    t_read();
    t_bulk();
    conclude();
  end

  initial begin
    repeat (3000) @(posedge core_clk);
    fail_count++;
    conclude();
  end
endmodule
`default_nettype wire
